// ===== verilog/fwr_top.sv
// Host sequencer for an asynchronous NOR flash: writes, status polls, reset.
// Assumes a single sys_clk; the flash pins are wired outside this module.
`timescale 1ns/1ps
module fwr_top
   import fwr_pkg::*;
#(
   parameter int                 AW           = 21,
   parameter logic [FWR_TMW-1:0] T_PROG_CYC   = fwr_us_cyc(FWR_T_PROG_US),
   parameter logic [FWR_TMW-1:0] T_BERASE_CYC = fwr_us_cyc(FWR_T_BERASE_US),
   parameter logic [FWR_TMW-1:0] T_CHIP_CYC   = fwr_us_cyc(FWR_T_CHIP_US),
   parameter logic [FWR_TMW-1:0] T_RSTAB_CYC  = fwr_us_cyc(FWR_T_RSTAB_US),
   parameter logic [FWR_TMW-1:0] T_GAP_CYC    = fwr_us_cyc(FWR_T_GAP_US)
) (
   input  wire logic          sys_clk,
   input  wire logic          rst_n,
   input  wire logic [7:0]    reg_addr,
   input  wire logic [31:0]   reg_wdata,
   input  wire logic          reg_wr,
   input  wire logic          reg_rd,
   output logic      [31:0]   reg_rdata,
   output logic               fl_ce_n,
   output logic               fl_we_n,
   output logic               fl_oe_n,
   output logic               fl_rst_n,
   output logic               fl_wp_n,
   output logic               fl_vpp_en,
   output logic      [AW-1:0] fl_addr,
   input  wire logic [15:0]   fl_dq_i,
   output logic      [15:0]   fl_dq_o,
   output logic               fl_dq_oe
);
   ////////////////////////////////////////////////////////////////////////////
   // Elaboration checks.
   if (AW < 1 || AW > 32) begin : g_bad_aw
      $error("fwr_top: address width must be 1 to 32");
   end
   if (T_GAP_CYC == '0 || T_RSTAB_CYC == '0) begin : g_bad_cyc
      $error("fwr_top: timing counts must be nonzero");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Types, helpers and submodules.
   typedef enum logic [8:0] {
      ST_PWR  = 9'h001,  // Power-up reset hold.
      ST_RLOW = 9'h002,  // Commanded reset hold.
      ST_RREC = 9'h004,  // Recovery after reset release.
      ST_IDLE = 9'h008,  // Waiting for a command.
      ST_WSET = 9'h010,  // Chip enable low, data driven.
      ST_WLOW = 9'h020,  // Write strobe low.
      ST_WREC = 9'h040,  // Strobes high, recovery.
      ST_RLO  = 9'h080,  // Read strobes low, access.
      ST_RHI  = 9'h100   // Read strobes high, bus float.
   } fwr_st_t;

   fwr_tmr_if #(.W(FWR_TMW)) tm0 ();  // Timeouts and abort hold.
   fwr_tmr_if #(.W(FWR_TMW)) tm1 ();  // Resume to suspend spacing.
   logic [15:0] dq_s;                 // Synchronised data bus.

   fwr_timer #(.W(FWR_TMW)) u_tm0 (.sys_clk(sys_clk), .rst_n(rst_n),
                                   .t(tm0.tmr));
   fwr_timer #(.W(FWR_TMW)) u_tm1 (.sys_clk(sys_clk), .rst_n(rst_n),
                                   .t(tm1.tmr));
   fwr_sync  #(.W(16))      u_sync (.sys_clk(sys_clk), .rst_n(rst_n),
                                    .d(fl_dq_i), .q(dq_s));

   // Timeout for a completion poll, by class.
   function automatic logic [FWR_TMW-1:0] tmo_of(input logic [2:0] cls);
      case (cls)
         3'h0:    tmo_of = T_PROG_CYC;
         3'h1:    tmo_of = T_BERASE_CYC;
         3'h3:    tmo_of = FWR_SUSP_P_CYC;
         3'h4:    tmo_of = FWR_SUSP_E_CYC;
         default: tmo_of = T_CHIP_CYC;
      endcase
   endfunction : tmo_of

   ////////////////////////////////////////////////////////////////////////////
   // Register file state.
   logic [6:0]         cfg_r, cfg_nxt;      // Pin levels and class.
   logic [AW-1:0]      adr_r, adr_nxt;      // Flash address.
   logic [15:0]        wd_r, wd_nxt;        // Flash write data.
   logic [FWR_C_W-1:0] cmd_r, cmd_nxt;      // Pending command.
   logic               cmdv_r, cmdv_nxt;    // Command pending.
   logic [4:1]         stk_r, stk_nxt;      // Sticky status bits.
   logic [31:0]        rdat_r, rdat_nxt;    // Read data.
   // Sequencer state.
   fwr_st_t            st_r, st_nxt;        // Sequencer state.
   logic [7:0]         ph_r, ph_nxt;        // Phase counter.
   logic               ce_r, ce_nxt;        // Chip enable, active low.
   logic               we_r, we_nxt;        // Write enable, active low.
   logic               oe_r, oe_nxt;        // Output enable, active low.
   logic               frs_r, frs_nxt;      // Flash reset, active low.
   logic               vpp_r, vpp_nxt;      // Program voltage enable.
   logic [AW-1:0]      fa_r, fa_nxt;        // Address pins.
   logic [15:0]        dqo_r, dqo_nxt;      // Data pins out.
   logic               dqe_r, dqe_nxt;      // Data pins enable.
   logic [7:0]         vc_r, vc_nxt;        // Program voltage settle.
   logic               vh_r, vh_nxt;        // Voltage hold.
   logic               run_r, run_nxt;      // Operation in flight.
   logic               poll_r, poll_nxt;    // Polling for ready.
   logic               wpg_r, wpg_nxt;      // Current write programs.
   logic               wrs_r, wrs_nxt;      // Current write resumes.
   logic [15:0]        srv_r, srv_nxt;      // Last status read value.
   // Events from the sequencer to the register file.
   logic               take;                // Pending command consumed.
   logic [4:1]         ev;                  // Sticky set events.
   logic               busy;                // Command pending or running.

   assign busy = cmdv_r | (st_r != ST_IDLE);

   ////////////////////////////////////////////////////////////////////////////
   // Register file next state. A set from the sequencer wins over a clear
   // written by software in the same cycle.
   always_comb begin
      cfg_nxt  = cfg_r;
      adr_nxt  = adr_r;
      wd_nxt   = wd_r;
      cmd_nxt  = cmd_r;
      cmdv_nxt = cmdv_r & ~take;
      stk_nxt  = stk_r | ev;
      rdat_nxt = 32'h0000_0000;
      if (reg_wr) begin
         case (reg_addr)
            FWR_REG_CTRL: begin
               // One command at a time; a second one is refused.
               if (cmdv_r) begin
                  stk_nxt[FWR_S_REF] = 1'b1;
               end else begin
                  cmd_nxt  = reg_wdata[FWR_C_W-1:0];
                  cmdv_nxt = 1'b1;
               end
            end
            FWR_REG_ADDR: adr_nxt = reg_wdata[AW-1:0];
            FWR_REG_WDAT: wd_nxt  = reg_wdata[15:0];
            FWR_REG_STAT: stk_nxt = (stk_r & ~reg_wdata[4:1]) | ev;
            FWR_REG_CFG:  cfg_nxt = reg_wdata[6:0];
            default: ;  // Unmapped writes are dropped.
         endcase
      end
      if (reg_rd) begin
         case (reg_addr)
            FWR_REG_ADDR: rdat_nxt = 32'(adr_r);
            FWR_REG_WDAT: rdat_nxt = {16'h0000, wd_r};
            FWR_REG_STAT: rdat_nxt = {srv_r, 9'h000, run_r, vh_r,
                                      stk_r, busy};
            FWR_REG_CFG:  rdat_nxt = {25'h0, cfg_r};
            default:      rdat_nxt = 32'h0000_0000;  // CTRL, unmapped.
         endcase
      end
   end

   // Register file flops.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r  <= FWR_CFG_RST;
         adr_r  <= '0;
         wd_r   <= 16'h0000;
         cmd_r  <= '0;
         cmdv_r <= 1'b0;
         stk_r  <= 4'h0;
         rdat_r <= 32'h0000_0000;
      end else begin
         cfg_r  <= cfg_nxt;
         adr_r  <= adr_nxt;
         wd_r   <= wd_nxt;
         cmd_r  <= cmd_nxt;
         cmdv_r <= cmdv_nxt;
         stk_r  <= stk_nxt;
         rdat_r <= rdat_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer next state. Chip enable falls a cycle before write enable
   // and both rise together, so the pulse widths hold for either framing.
   always_comb begin
      st_nxt = st_r;
      ph_nxt = (ph_r == 8'h00) ? 8'h00 : 8'(ph_r - 1'b1);
      {ce_nxt, we_nxt, oe_nxt, frs_nxt} = {ce_r, we_r, oe_r, frs_r};
      {fa_nxt, dqo_nxt, dqe_nxt} = {fa_r, dqo_r, dqe_r};
      {vh_nxt, run_nxt, poll_nxt} = {vh_r, run_r, poll_r};
      {wpg_nxt, wrs_nxt, srv_nxt} = {wpg_r, wrs_r, srv_r};
      take = 1'b0;
      ev   = 4'h0;
      tm0.load = 1'b0;
      tm0.count = '0;
      tm1.load = 1'b0;
      tm1.count = '0;
      // Voltage stays up until a started operation succeeds or a reset is commanded.
      vpp_nxt = cfg_r[FWR_G_VPP] | vh_r;
      vc_nxt = !vpp_r ? 8'h00 :
               (vc_r == FWR_VPS_CYC) ? vc_r : 8'(vc_r + 1'b1);
      case (st_r)
         ST_PWR, ST_RLOW: begin
            // The long hold applies only when an operation was running.
            if (ph_r == 8'h00 && tm0.done) begin
               frs_nxt = 1'b1;
               ph_nxt  = FWR_RREC_CYC;
               st_nxt  = ST_RREC;
            end
         end
         ST_RREC: begin
            if (ph_r == 8'h00) begin
               st_nxt = ST_IDLE;
            end
         end
         ST_IDLE: begin
            if (!cmdv_r) begin
               st_nxt = ST_IDLE;
            end else if (cmd_r[FWR_C_RST]) begin
               take      = 1'b1;
               frs_nxt   = 1'b0;
               ph_nxt    = FWR_PLPH_CYC;
               tm0.load  = 1'b1;
               tm0.count = run_r ? T_RSTAB_CYC : '0;
               {vh_nxt, run_nxt, poll_nxt} = 3'b000;
               st_nxt    = ST_RLOW;
            end else if (cmd_r[FWR_C_WR]) begin
               if (cmd_r[FWR_C_PROG] && !cfg_r[FWR_G_VPP]) begin
                  take = 1'b1;
                  ev[FWR_S_REF] = 1'b1;
               end else if (!cmd_r[FWR_C_SUSP] || tm1.done) begin
                  take    = 1'b1;
                  fa_nxt  = adr_r;
                  dqo_nxt = wd_r;
                  dqe_nxt = 1'b1;
                  ce_nxt  = 1'b0;
                  wpg_nxt = cmd_r[FWR_C_PROG];
                  wrs_nxt = cmd_r[FWR_C_RES];
                  st_nxt  = ST_WSET;
               end
            end else if (cmd_r[FWR_C_RD] || cmd_r[FWR_C_POLL]) begin
               take     = 1'b1;
               fa_nxt   = adr_r;
               {ce_nxt, oe_nxt} = 2'b00;
               ph_nxt   = FWR_RD_CYC;
               poll_nxt = cmd_r[FWR_C_POLL];
               tm0.load  = cmd_r[FWR_C_POLL];
               tm0.count = tmo_of(cfg_r[FWR_G_CLS +: 3]);
               st_nxt   = ST_RLO;
            end else begin
               take = 1'b1;  // Empty command.
            end
         end
         ST_WSET: begin
            we_nxt = 1'b0;
            ph_nxt = FWR_WP_CYC;
            st_nxt = ST_WLOW;
         end
         ST_WLOW: begin
            if (ph_r == 8'h00 && (!wpg_r || vc_r == FWR_VPS_CYC)) begin
               {ce_nxt, we_nxt} = 2'b11;
               dqe_nxt = 1'b0;
               ph_nxt  = FWR_REC_CYC;
               ev[FWR_S_DONE] = 1'b1;
               if (wpg_r) begin
                  run_nxt = 1'b1;
                  vh_nxt  = 1'b1;
               end
               tm1.load  = wrs_r;
               tm1.count = T_GAP_CYC;
               st_nxt  = ST_WREC;
            end
         end
         ST_WREC: begin
            if (ph_r == 8'h00) begin
               st_nxt = ST_IDLE;
            end
         end
         ST_RLO: begin
            if (ph_r == 8'h00) begin
               srv_nxt = dq_s;
               {ce_nxt, oe_nxt} = 2'b11;
               ph_nxt  = FWR_HZ_CYC;
               st_nxt  = ST_RHI;
            end
         end
         ST_RHI: begin
            if (ph_r != 8'h00) begin
               st_nxt = ST_RHI;
            end else if (!poll_r) begin
               ev[FWR_S_DONE] = 1'b1;
               st_nxt = ST_IDLE;
            end else if (srv_r[FWR_SR_RDY]) begin
               ev[FWR_S_DONE] = 1'b1;
               ev[FWR_S_ERR]  = (srv_r & FWR_SR_ERR) != 16'h0000;
               vh_nxt   = vh_r & ((srv_r & FWR_SR_ERR) != 16'h0000);
               run_nxt  = 1'b0;
               poll_nxt = 1'b0;
               st_nxt   = ST_IDLE;
            end else if (tm0.done) begin
               ev[FWR_S_TMO] = 1'b1;
               poll_nxt = 1'b0;
               st_nxt   = ST_IDLE;
            end else begin
               {ce_nxt, oe_nxt} = 2'b00;
               ph_nxt = FWR_RD_CYC;
               st_nxt = ST_RLO;
            end
         end
         default: begin
            st_nxt = ST_IDLE;
         end
      endcase
   end

   // Sequencer flops. The flash reset is held low from power-up.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         st_r   <= ST_PWR;
         ph_r   <= FWR_PLPH_CYC;
         {ce_r, we_r, oe_r, frs_r} <= 4'b1110;
         {vpp_r, vh_r, run_r, poll_r, wpg_r, wrs_r} <= 6'h00;
         fa_r   <= '0;
         dqo_r  <= 16'h0000;
         dqe_r  <= 1'b0;
         vc_r   <= 8'h00;
         srv_r  <= 16'h0000;
      end else begin
         st_r   <= st_nxt;
         ph_r   <= ph_nxt;
         {ce_r, we_r, oe_r, frs_r} <= {ce_nxt, we_nxt, oe_nxt, frs_nxt};
         {vpp_r, vh_r, run_r, poll_r} <= {vpp_nxt, vh_nxt, run_nxt, poll_nxt};
         {wpg_r, wrs_r} <= {wpg_nxt, wrs_nxt};
         fa_r   <= fa_nxt;
         dqo_r  <= dqo_nxt;
         dqe_r  <= dqe_nxt;
         vc_r   <= vc_nxt;
         srv_r  <= srv_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs, each straight from a flop.
   assign reg_rdata = rdat_r;
   assign fl_ce_n   = ce_r;
   assign fl_we_n   = we_r;
   assign fl_oe_n   = oe_r;
   assign fl_rst_n  = frs_r;
   assign fl_wp_n   = cfg_r[FWR_G_WP];
   assign fl_vpp_en = vpp_r;
   assign fl_addr   = fa_r;
   assign fl_dq_o   = dqo_r;
   assign fl_dq_oe  = dqe_r;
endmodule : fwr_top

// ===== verilog/fwr_pkg.sv
// Constants, register map and timing counts for the flash sequencer host.
// Assumes a 200 MHz system clock and an asynchronous parallel NOR flash.
//
// Summary of operation
// - Either strobe may frame a write.
// - Write pulse lasts at least 60 ns.
// - Strobes stay high 30 ns between pulses.
// - Wait 150 ns after reset before writing.
// - Wait 30 ns after write before reading.
// - Program voltage valid 200 ns before write end.
// - Hold program voltage until status shows success.
// - Hold reset low at least 100 ns.
// - Reset held 100 ns after power is stable.
// - Chip erase timeout allows 350 s.
// - Keep 500 us from resume to suspend.
// - No program or erase without program voltage.
package fwr_pkg;
   ////////////////////////////////////////////////////////////////////////////
   // Clock and conversion helpers.
   localparam int FWR_CLK_NS = 5;   // System clock period in ns.
   localparam int FWR_TMW    = 40;  // Timer width, enough for 350 s.

   // Least time in ns to cycles, rounded up, never below one.
   function automatic int fwr_min_cyc(input int ns);
      int c;
      c = (ns + FWR_CLK_NS - 1) / FWR_CLK_NS;
      return (c < 1) ? 1 : c;
   endfunction : fwr_min_cyc

   // Longest time in us to cycles, rounded down, never below one.
   function automatic logic [FWR_TMW-1:0] fwr_us_cyc(input longint us);
      longint c;
      c = (us * 64'd1000) / FWR_CLK_NS;
      return (c < 1) ? 40'h1 : c[FWR_TMW-1:0];
   endfunction : fwr_us_cyc

   ////////////////////////////////////////////////////////////////////////////
   // Pin timing, in ns as printed, and derived phase counts.
   localparam int FWR_T_WP_NS   = 60;   // Write pulse low.
   localparam int FWR_T_WPH_NS  = 30;   // Write pulse high.
   localparam int FWR_T_PHWL_NS = 150;  // Reset high to write strobe low.
   localparam int FWR_T_WHGL_NS = 30;   // Write recovery before read.
   localparam int FWR_T_VPS_NS  = 200;  // Program voltage setup.
   localparam int FWR_T_PLPH_NS = 100;  // Reset low width.
   localparam int FWR_T_ACC_NS  = 90;   // Read access time.
   localparam int FWR_T_QRY_NS  = 100;  // Extra ready delay after query.
   localparam int FWR_T_HZ_NS   = 20;   // Output float after strobes high.
   localparam int FWR_T_PHQV_NS = 150;  // Reset high to valid output.
   localparam int FWR_SYNC_LAT  = 2;    // Data bus synchroniser depth.

   localparam logic [7:0] FWR_WP_CYC   = 8'(fwr_min_cyc(FWR_T_WP_NS));
   localparam logic [7:0] FWR_REC_CYC  = 8'(fwr_min_cyc(
      (FWR_T_WPH_NS > FWR_T_WHGL_NS) ? FWR_T_WPH_NS : FWR_T_WHGL_NS));
   localparam logic [7:0] FWR_RREC_CYC = 8'(fwr_min_cyc(
      (FWR_T_PHWL_NS > FWR_T_PHQV_NS) ? FWR_T_PHWL_NS : FWR_T_PHQV_NS));
   localparam logic [7:0] FWR_VPS_CYC  = 8'(fwr_min_cyc(FWR_T_VPS_NS));
   localparam logic [7:0] FWR_PLPH_CYC = 8'(fwr_min_cyc(FWR_T_PLPH_NS));
   localparam logic [7:0] FWR_RD_CYC   = 8'(fwr_min_cyc(
      FWR_T_ACC_NS + FWR_T_QRY_NS) + FWR_SYNC_LAT);
   localparam logic [7:0] FWR_HZ_CYC   = 8'(fwr_min_cyc(FWR_T_HZ_NS));

   ////////////////////////////////////////////////////////////////////////////
   // Operation limits, in their printed units.
   localparam longint FWR_T_PROG_US   = 200;      // Word program.
   localparam longint FWR_T_BERASE_US = 8000000;  // Block erase, 8 s.
   localparam longint FWR_T_CHIP_US   = 350000000; // Full chip, 350 s.
   localparam longint FWR_T_SUSP_P_US = 10;       // Program suspend.
   localparam longint FWR_T_SUSP_E_US = 20;       // Erase suspend.
   localparam longint FWR_T_RSTAB_US  = 22;       // Reset abort.
   localparam longint FWR_T_GAP_US    = 500;      // Resume to suspend.
   localparam logic [FWR_TMW-1:0] FWR_SUSP_P_CYC = fwr_us_cyc(FWR_T_SUSP_P_US);
   localparam logic [FWR_TMW-1:0] FWR_SUSP_E_CYC = fwr_us_cyc(FWR_T_SUSP_E_US);

   ////////////////////////////////////////////////////////////////////////////
   // Register map and fields.
   localparam logic [7:0] FWR_REG_CTRL = 8'h00;  // Command strobes.
   localparam logic [7:0] FWR_REG_ADDR = 8'h04;  // Flash word address.
   localparam logic [7:0] FWR_REG_WDAT = 8'h08;  // Flash write data.
   localparam logic [7:0] FWR_REG_STAT = 8'h0C;  // Status, write 1 clears.
   localparam logic [7:0] FWR_REG_CFG  = 8'h10;  // Pin levels, timeout.
   localparam int FWR_C_WR = 0;     // Issue one write cycle.
   localparam int FWR_C_RD = 1;     // Issue one status read.
   localparam int FWR_C_RST = 2;    // Pulse the flash reset.
   localparam int FWR_C_POLL = 3;   // Poll until ready or timeout.
   localparam int FWR_C_PROG = 4;   // Write starts program or erase.
   localparam int FWR_C_RES = 5;    // Write is an erase resume.
   localparam int FWR_C_SUSP = 6;   // Write is an erase suspend.
   localparam int FWR_C_W = 7;      // Command field width.
   localparam int FWR_G_VPP = 0;    // Program voltage request.
   localparam int FWR_G_WP = 1;     // Write-protect pin level.
   localparam int FWR_G_CLS = 4;    // Timeout class, three bits.
   localparam logic [6:0] FWR_CFG_RST = 7'h02;
   localparam int FWR_S_BUSY = 0, FWR_S_DONE = 1, FWR_S_TMO = 2;
   localparam int FWR_S_ERR = 3, FWR_S_REF = 4, FWR_S_VH = 5;
   localparam int FWR_S_RUN = 6, FWR_S_VAL = 16;
   localparam int FWR_SR_RDY = 7;                 // Ready status bit.
   localparam logic [15:0] FWR_SR_ERR = 16'h003A; // Operation error bits.
endpackage : fwr_pkg

// ===== verilog/fwr_tmr_if.sv
// Interface between the sequencer and a down-counting timer.
// Assumes both ends share sys_clk.
`timescale 1ns/1ps
interface fwr_tmr_if #(parameter int W = 40);
   logic         load;   // Load the count this cycle.
   logic [W-1:0] count;  // Cycles until done.
   logic         done;   // Timer has run out.
   modport ctl (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface : fwr_tmr_if

// ===== verilog/fwr_timer.sv
// Down-counting timer used for timeouts and long reset holds.
// Assumes load is a one-cycle pulse from logic on sys_clk.
`timescale 1ns/1ps
module fwr_timer #(
   parameter int W = 40
) (
   input  wire logic sys_clk,
   input  wire logic rst_n,
   fwr_tmr_if.tmr    t
);
   ////////////////////////////////////////////////////////////////////////////
   logic [W-1:0] cnt_r;    // Remaining cycles.
   logic [W-1:0] cnt_nxt;  // Next remaining cycles.

   // A load restarts the count; otherwise it falls to zero and stays.
   always_comb begin
      cnt_nxt = cnt_r;
      if (t.load) begin
         cnt_nxt = t.count;
      end else if (cnt_r != '0) begin
         cnt_nxt = W'(cnt_r - 1'b1);
      end
   end

   // Register only.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r <= '0;
      end else begin
         cnt_r <= cnt_nxt;
      end
   end

   assign t.done = (cnt_r == '0);
endmodule : fwr_timer

// ===== verilog/fwr_sync.sv
// Two-stage synchroniser for the flash data bus.
// Assumes the bus is held stable while it is sampled.
`timescale 1ns/1ps
module fwr_sync #(
   parameter int W = 16
) (
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   ////////////////////////////////////////////////////////////////////////////
   logic [W-1:0] s1_r;   // First stage, read only by the second.
   logic [W-1:0] s1_nxt; // First stage next value.
   logic [W-1:0] s2_r;   // Second stage.

   // The pin is asynchronous to sys_clk.
   always_comb begin
      s1_nxt = d;
   end

   // Register only.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= '0;
         s2_r <= '0;
      end else begin
         s1_r <= s1_nxt;
         s2_r <= s1_r;
      end
   end

   assign q = s2_r;
endmodule : fwr_sync

// ===== tb/fwr_top_props.sv
// Checker on the flash pins of fwr_top.
// Bound to every fwr_top below.
`timescale 1ns/1ps
module fwr_top_props (
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic fl_ce_n,
   input wire logic fl_we_n,
   input wire logic fl_oe_n,
   input wire logic fl_rst_n,
   input wire logic fl_vpp_en
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   property p_frm; $fell(fl_we_n) |-> !$past(fl_ce_n); endproperty
   a_frm: assert property (p_frm) else $error("frame");
   property p_wp; $fell(fl_we_n) |-> !fl_we_n throughout (##11 1); endproperty
   a_wp: assert property (p_wp) else $error("pulse");
   property p_wph; $rose(fl_we_n) |-> fl_we_n[*6]; endproperty
   a_wph: assert property (p_wph) else $error("high");
   property p_phw; $rose(fl_rst_n) |-> fl_we_n throughout (##29 1); endproperty
   a_phw: assert property (p_phw) else $error("reset gap");
   property p_wgl; $rose(fl_we_n) |-> fl_oe_n[*6]; endproperty
   a_wgl: assert property (p_wgl) else $error("read gap");
   property p_vps;
      $rose(fl_we_n) && fl_vpp_en |-> $past(fl_vpp_en, 40);
   endproperty
   a_vps: assert property (p_vps) else $error("vpp");
   property p_pl;
      $fell(fl_rst_n) |-> !fl_rst_n throughout (##19 1);
   endproperty
   a_pl: assert property (p_pl) else $error("rst");
   property p_pu; $rose(rst_n) |-> !fl_rst_n throughout (##19 1); endproperty
   a_pu: assert property (p_pu) else $error("power");
   c_wr: cover property ($rose(fl_we_n));
   c_rd: cover property ($rose(fl_oe_n));
   c_rst: cover property ($rose(fl_rst_n));
endmodule : fwr_top_props
bind fwr_top fwr_top_props u_props (.*);

// ===== tb/fwr_flash_model.sv
// Behavioural flash: status word, busy time, reset abort.
// Strobes come from fwr_top; dq shows junk when not read.
`timescale 1ns/1ps
module fwr_flash_model #(parameter int BUSY_NS = 500) (
   input wire logic ce_n,
   input wire logic we_n,
   input wire logic oe_n,
   input wire logic rst_n,
   output wire logic [15:0] dq
);
   logic [15:0] sr = 16'h0080; // Ready, no errors.
   wire wr_end = ce_n | we_n;
   // Ready drops at write end and returns later.
   always @(posedge wr_end) if (rst_n === 1'b1) begin
      sr[7] = 1'b0;
      #(BUSY_NS) sr[7] = 1'b1;
   end
   always @(negedge rst_n) sr = 16'h0080;
   // Read timing; released bus shows the inverse.
   assign #90 dq = (!ce_n && !oe_n && rst_n) ? sr : ~sr;
endmodule : fwr_flash_model

// ===== tb/fwr_top_test.sv
// Bench for fwr_top against the flash model.
// Needs package, design, model and checker first.
`timescale 1ns/1ps
module fwr_top_test;
   logic sys_clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
   logic fl_ce_n, fl_we_n, fl_oe_n, fl_rst_n, fl_dq_oe, fl_wp_n, fl_vpp_en;
   logic [15:0] fl_dq_i, fl_dq_o, fl_dq, wdat_seen;
   logic [20:0] fl_addr, wadr_seen;  // Default address width.
   int err_total = 0, num_checks = 0;
   assign fl_dq_i = fl_dq_oe ? fl_dq_o : fl_dq; // Shared data wire.
   fwr_top #(.T_PROG_CYC(40'hC8), .T_RSTAB_CYC(40'h64), .T_GAP_CYC(40'hC8))
   dut (.sys_clk, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
      .reg_rdata, .fl_ce_n, .fl_we_n, .fl_oe_n, .fl_rst_n, .fl_wp_n,
      .fl_vpp_en, .fl_addr, .fl_dq_i, .fl_dq_o, .fl_dq_oe);
   fwr_flash_model u_fl (.ce_n(fl_ce_n), .we_n(fl_we_n), .oe_n(fl_oe_n),
      .rst_n(fl_rst_n), .dq(fl_dq));
   initial forever #2.5 sys_clk = ~sys_clk;
   // One write cycle, then one idle cycle, so that a following call never
   // assigns the strobe twice in one time step.
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      reg_addr <= a;
      reg_wdata <= v;
      reg_wr <= 1'b1;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
      @(posedge sys_clk);
   endtask : wr
   // Read data stand only in the cycle after the strobe edge.
   task automatic rd(input logic [7:0] a);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
      @(posedge sys_clk);
   endtask : rd
   // Pin levels and captured write cycles.
   task automatic chk_pin(input logic [31:0] g, e);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] %0t pin got %h want %h", $time, g, e);
      end
   endtask : chk_pin
   // Address and data on the pins as a write pulse ends.
   always @(posedge fl_we_n) begin
      wadr_seen = fl_addr;
      wdat_seen = fl_dq_o;
   end
   task automatic chk(input logic [31:0] m, e);
      num_checks++;
      if ((d & m) !== e) begin
         err_total++;
         $display("[ERR] %0t got %h want %h", $time, d & m, e);
      end
   endtask : chk
   // Bounded status poll until the busy bit drops.
   task automatic idle;
      repeat (4) @(posedge sys_clk);
      rd(8'h0C);
      repeat (400) if (d[0] !== 1'b0) rd(8'h0C);
      chk(32'h1, 32'h0);
   endtask : idle
   task automatic t_refuse;
      wr(8'h10, 32'h0);
      wr(8'h00, 32'h11);
      idle();
      chk(32'h10, 32'h10);
      chk_pin(fl_vpp_en, 1'b0);
      chk_pin(fl_wp_n, 1'b0);
      wr(8'h0C, 32'h1E);
      rd(8'h0C);
      chk(32'h1E, 32'h0);
      rd(8'h20);
      chk(32'hFFFFFFFF, 32'h0);
   endtask : t_refuse
   task automatic t_prog;
      wr(8'h10, 32'h3);
      wr(8'h04, 32'h12345);
      wr(8'h08, 32'hBEEF);
      wr(8'h00, 32'h11);
      idle();
      chk_pin(wadr_seen, 32'h12345);
      chk_pin(wdat_seen, 32'hBEEF);
      chk_pin(fl_vpp_en, 1'b1);
      chk_pin(fl_wp_n, 1'b1);
      wr(8'h00, 32'h2);
      idle();
      chk(32'hFFFF0000, 32'h0);
      wr(8'h00, 32'h8);
      idle();
      chk(32'hFFFF002E, 32'h00800002);
   endtask : t_prog
   task automatic t_rst;
      wr(8'h00, 32'h11);
      idle();
      chk(32'h20, 32'h20);
      wr(8'h10, 32'h2);
      repeat (2) @(posedge sys_clk);
      chk_pin(fl_vpp_en, 1'b1);
      wr(8'h00, 32'h4);
      idle();
      chk_pin(fl_vpp_en, 1'b0);
      wr(8'h00, 32'h8);
      idle();
      chk(32'hFFFF0024, 32'h00800000);
   endtask : t_rst
   task automatic conclude;
      if (err_total == 0 && num_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : conclude
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (60) @(posedge sys_clk);
      t_refuse();
      t_prog();
      t_rst();
      conclude();
   end
   initial begin
      #100000 err_total++;
      conclude();
   end
endmodule : fwr_top_test
